// file: design/wse_engine.sv
// Purpose: Waveform sequencer engine with idle control
// Assumes: Wishbone classic slave, one clock
// Notes: Instruction is 4 bytes; mem byte n of state s = 4*(8*desc+s)+n
//
// Function
// - Seven programmable states plus idle state seven
// - States drive controls, data, address, pointer, event
// - Decision state combines two terms and branches
// - Timed state holds 2*count+1 cycles, one to 255; state 0 entered by trigger holds one cycle
// - 128-byte waveform memory at E400 to E47F
// - Memory reachable only in engine mode 10
// - Memory bytes individually rewritable
// - Four descriptors selectable per transfer type
// - Seven 32-bit instructions per descriptor
// - State changes only on clock edges
// - Branch to idle ends the waveform
// - Idle signals come from idle registers
// - No new waveform until done bit set
// - Done reads zero busy, one idle
// - Idle bus floats or keeps last value
// - Tristate mode off: six levels, enabled except open-drain high levels
// - Config bit selects push-pull or open drain
// - Tristate mode on: four idle enables, four idle levels; states drive six of each
`timescale 1ns/1ps
`include "wse_cfg.svh"
module wse_engine #(
   parameter int DW = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [15:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic [5:0] wait_in_i,
   input wire logic fifo_flag_i,
   input wire logic [DW-1:0] fifo_data_bus_i,
   input wire logic [DW-1:0] wr_data_i,
   output logic [DW-1:0] fifo_data_bus_o,
   output logic fifo_data_bus_oe_o,
   output logic [5:0] control_strobe_out_o,
   output logic [5:0] control_strobe_out_oe_o,
   output logic [8:0] engine_address_out_o,
   output logic fifo_advance_o,
   output logic waveform_event_irq_o,
   output logic completion_irq_o,
   output logic [DW-1:0] rd_data_o,
   output logic rd_valid_o
);
   // ---------------------------------------------
   // Registers and storage
   // ---------------------------------------------
   logic [7:0] wf_mem [0:`WSE_MEM_BYTES-1];
   logic [7:0] idle_status_control;
   logic [7:0] idle_control_levels;
   logic [7:0] control_output_config;
   logic [7:0] descriptor_select_reg;
   logic [1:0] interface_config_field;
   logic firmware_ready_flag;
   logic [7:0] xfer_count;
   logic [1:0] trig_type;
   logic wse_done;
   logic [1:0] desc;
   logic [2:0] cur;
   logic [7:0] dwell;
   logic [DW-1:0] last_data;
   logic [5:0] wait_s1;
   logic [5:0] wait_s2;
   logic flag_s1;
   logic flag_s2;
   wse_pkg::wse_state_t st;
   // ---------------------------------------------
   // Bus decode
   // ---------------------------------------------
   logic req;
   logic wr;
   logic in_mem;
   logic mem_ok;
   logic trig_wr;
   logic abort_wr;
   logic [4:0] mem_word;
   assign req = cyc_i && stb_i && !ack_o;
   assign wr = req && we_i;
   assign in_mem = (adr_i >= `WSE_MEM_BASE) && (adr_i <= `WSE_MEM_LAST);
   assign mem_ok = in_mem && (interface_config_field == `WSE_IF_ENGINE);
   assign mem_word = adr_i[6:2];
   assign trig_wr = wr && (adr_i == `WSE_OFF_TRIG) && sel_i[0] && wse_done;
   assign abort_wr = wr && (adr_i == `WSE_OFF_ABORT) && sel_i[0];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req;
      end
   end
   // Byte-lane memory writes
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_lane
         always_ff @(posedge clk_i) begin
            if (wr && mem_ok && sel_i[gb]) begin
               wf_mem[{mem_word, 2'(gb)}] <= dat_i[8*gb +: 8];
            end
         end
      end
   endgenerate
   // Config registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_status_control <= 8'h00;
         idle_control_levels <= 8'h00;
         control_output_config <= 8'h00;
         descriptor_select_reg <= `WSE_WF_SEL_RST;
         interface_config_field <= 2'h0;
         firmware_ready_flag <= 1'b0;
         xfer_count <= 8'h00;
      end else if (wr && sel_i[0]) begin
         case (adr_i)
            `WSE_OFF_IDLE_CS: idle_status_control <= {1'b0, dat_i[6:0]};
            `WSE_OFF_IDLE_CTL: idle_control_levels <= dat_i[7:0];
            `WSE_OFF_CTL_CFG: control_output_config <= dat_i[7:0];
            `WSE_OFF_WF_SEL: descriptor_select_reg <= dat_i[7:0];
            `WSE_OFF_IF_CFG: interface_config_field <= dat_i[1:0];
            `WSE_OFF_READY: firmware_ready_flag <= dat_i[`WSE_RDY_BIT];
            `WSE_OFF_TC: xfer_count <= dat_i[7:0];
            default: begin
            end
         endcase
      end else if (st == wse_pkg::WSE_ST_RUN && fifo_advance_o && xfer_count != 8'h00) begin
         xfer_count <= xfer_count - 8'h01;
      end
   end
   // Read mux
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (req && !we_i) begin
         if (in_mem) begin
            dat_o <= mem_ok ? {wf_mem[{mem_word, 2'h3}], wf_mem[{mem_word, 2'h2}],
                               wf_mem[{mem_word, 2'h1}], wf_mem[{mem_word, 2'h0}]} : 32'h0000_0000;
         end else begin
            case (adr_i)
               `WSE_OFF_IDLE_CS: dat_o <= {24'h0, wse_done, idle_status_control[6:0]};
               `WSE_OFF_IDLE_CTL: dat_o <= {24'h0, idle_control_levels};
               `WSE_OFF_CTL_CFG: dat_o <= {24'h0, control_output_config};
               `WSE_OFF_TRIG: dat_o <= {24'h0, wse_done, 5'h0, trig_type};
               `WSE_OFF_WF_SEL: dat_o <= {24'h0, descriptor_select_reg};
               `WSE_OFF_IF_CFG: dat_o <= {30'h0, interface_config_field};
               `WSE_OFF_READY: dat_o <= {24'h0, firmware_ready_flag, 7'h0};
               `WSE_OFF_TC: dat_o <= {24'h0, xfer_count};
               default: dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
   // ---------------------------------------------
   // Input synchronisers
   // ---------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wait_s1 <= 6'h00;
         wait_s2 <= 6'h00;
         flag_s1 <= 1'b0;
         flag_s2 <= 1'b0;
      end else begin
         wait_s1 <= wait_in_i;
         wait_s2 <= wait_s1;
         flag_s1 <= fifo_flag_i;
         flag_s2 <= flag_s1;
      end
   end
   // ---------------------------------------------
   // Instruction fetch and decision
   // ---------------------------------------------
   logic [4:0] iw;
   logic [4:0] nw;
   wse_pkg::wse_instr_t ins;
   wse_pkg::wse_instr_t nins;
   wse_pkg::wse_branch_t brn;
   logic [7:0] terms;
   logic ta;
   logic tb;
   logic lres;
   logic [2:0] tgt;
   logic [1:0] sel_desc;
   assign iw = {desc, cur};
   // Four bytes of instruction; brn reads bytes 0-1 of word slot 7 and is unused
   assign ins = {wf_mem[{iw, 2'h3}], wf_mem[{iw, 2'h2}], wf_mem[{iw, 2'h1}], wf_mem[{iw, 2'h0}]};
   assign brn = {wf_mem[{desc, 3'h7, 2'h1}][5:0], wf_mem[{desc, 3'h7, 2'h0}]} >> 0;
   assign terms = {xfer_count == 8'h00, firmware_ready_flag, flag_s2, wait_s2[4:0]};
   assign ta = terms[ins.term_a];
   assign tb = terms[ins.term_b];
   always_comb begin
      case (ins.lfunc)
         wse_pkg::WSE_LF_AND: lres = ta & tb;
         wse_pkg::WSE_LF_OR: lres = ta | tb;
         wse_pkg::WSE_LF_XOR: lres = ta ^ tb;
         default: lres = 1'b0;
      endcase
   end
   // Branch targets live in spare bits: br1 = spare[4:2], br0 = {spare[1:0], 0}; count in byte 3 bits 6:0
   assign tgt = lres ? ins.spare[4:2] : {ins.spare[1:0], 1'b0};
   assign sel_desc = descriptor_select_reg[2*trig_type +: 2];
   always_comb begin
      if (ins.decide) begin
         nw = {desc, tgt};
      end else begin
         nw = {desc, cur + 3'h1};
      end
   end
   assign nins = {wf_mem[{nw, 2'h3}], wf_mem[{nw, 2'h2}], wf_mem[{nw, 2'h1}], wf_mem[{nw, 2'h0}]};
   // ---------------------------------------------
   // Sequencer
   // ---------------------------------------------
   logic leave;
   logic [2:0] next_cur;
   assign leave = ins.decide || dwell == 8'h00;
   always_comb begin
      if (ins.decide) begin
         next_cur = tgt;
      end else if (cur == `WSE_LAST_STATE) begin
         next_cur = `WSE_IDLE_STATE;
      end else begin
         next_cur = cur + 3'h1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= wse_pkg::WSE_ST_IDLE;
         wse_done <= 1'b1;
         cur <= `WSE_IDLE_STATE;
         desc <= 2'h0;
         trig_type <= 2'h0;
         dwell <= 8'h00;
      end else if (st == wse_pkg::WSE_ST_IDLE) begin
         if (trig_wr) begin
            st <= wse_pkg::WSE_ST_RUN;
            wse_done <= 1'b0;
            trig_type <= dat_i[1:0];
            desc <= descriptor_select_reg[2*dat_i[1:0] +: 2];
            cur <= 3'h0;
            dwell <= 8'h00;
         end
      end else if (abort_wr || (leave && next_cur == `WSE_IDLE_STATE)) begin
         st <= wse_pkg::WSE_ST_IDLE;
         wse_done <= 1'b1;
         cur <= `WSE_IDLE_STATE;
      end else if (leave) begin
         cur <= next_cur;
         dwell <= nins.decide ? 8'h00 : {wf_mem[{nw, 2'h3}][6:0], 1'b0};
      end else begin
         dwell <= dwell - 8'h01;
      end
   end
   // ---------------------------------------------
   // Output stage
   // ---------------------------------------------
   logic entry;
   logic task_now;
   logic [5:0] idle_lvl;
   logic [5:0] idle_oe;
   logic [5:0] run_oe;
   assign entry = (st == wse_pkg::WSE_ST_RUN) && (dwell == 8'h00 || ins.decide);
   assign task_now = entry && (!ins.decide || ins.reexec);
   always_comb begin
      if (control_output_config[`WSE_TRI_BIT]) begin
         idle_lvl = {2'h0, idle_control_levels[3:0]};
         idle_oe = {2'h0, idle_control_levels[7:4]};
      end else begin
         idle_lvl = idle_control_levels[5:0];
         // Open drain drives only the low level
         idle_oe = ~(control_output_config[5:0] & idle_control_levels[5:0]);
      end
      run_oe = control_output_config[`WSE_TRI_BIT] ? ins.ctl_oe : ~(control_output_config[5:0] & ins.ctl_level);
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_strobe_out_o <= 6'h00;
         control_strobe_out_oe_o <= 6'h00;
         fifo_data_bus_o <= '0;
         fifo_data_bus_oe_o <= 1'b0;
         last_data <= '0;
         engine_address_out_o <= 9'h000;
         fifo_advance_o <= 1'b0;
         waveform_event_irq_o <= 1'b0;
         completion_irq_o <= 1'b0;
         rd_data_o <= '0;
         rd_valid_o <= 1'b0;
      end else begin
         // Abort also ends the waveform
         completion_irq_o <= st == wse_pkg::WSE_ST_RUN && (abort_wr || (leave && next_cur == `WSE_IDLE_STATE));
         fifo_advance_o <= task_now && ins.next_fifo;
         waveform_event_irq_o <= task_now && ins.irq;
         rd_valid_o <= st == wse_pkg::WSE_ST_RUN && ins.sample_data;
         if (st == wse_pkg::WSE_ST_RUN && ins.sample_data) begin
            rd_data_o <= fifo_data_bus_i;
         end
         if (task_now && ins.inc_addr) begin
            engine_address_out_o <= engine_address_out_o + 9'h001;
         end
         if (st == wse_pkg::WSE_ST_RUN) begin
            control_strobe_out_o <= ins.ctl_level;
            control_strobe_out_oe_o <= run_oe;
            fifo_data_bus_oe_o <= ins.drive_data;
            if (ins.drive_data) begin
               fifo_data_bus_o <= wr_data_i;
               last_data <= wr_data_i;
            end
         end else begin
            control_strobe_out_o <= idle_lvl;
            control_strobe_out_oe_o <= idle_oe;
            fifo_data_bus_o <= last_data;
            fifo_data_bus_oe_o <= idle_status_control[`WSE_IDLE_BUS_DRIVE_BIT];
         end
      end
   end
endmodule

// file: design/wse_cfg.svh
// Purpose: Constants for the waveform sequencer engine
// Assumes: Word-aligned Wishbone register map
// Notes: Offsets are byte addresses
`ifndef WSE_CFG_SVH
`define WSE_CFG_SVH
`define WSE_MEM_BASE 16'hE400
`define WSE_MEM_LAST 16'hE47F
`define WSE_MEM_BYTES 128
`define WSE_OFF_IDLE_CS 16'h0000
`define WSE_OFF_IDLE_CTL 16'h0004
`define WSE_OFF_CTL_CFG 16'h0008
`define WSE_OFF_TRIG 16'h000C
`define WSE_OFF_ABORT 16'h0010
`define WSE_OFF_WF_SEL 16'h0014
`define WSE_OFF_IF_CFG 16'h0018
`define WSE_OFF_READY 16'h001C
`define WSE_OFF_TC 16'h0020
`define WSE_DONE_BIT 7
`define WSE_IDLE_BUS_DRIVE_BIT 0
`define WSE_TRI_BIT 7
`define WSE_RDY_BIT 7
`define WSE_IF_ENGINE 2'h2
`define WSE_WF_SEL_RST 8'hE4
`define WSE_IDLE_STATE 3'h7
`define WSE_LAST_STATE 3'h6
`endif

// file: design/wse_pkg.sv
// Purpose: Types for the waveform sequencer engine
// Assumes: Used with wse_cfg.svh
// Notes: Instruction layout is a local encoding
package wse_pkg;
   typedef enum logic [1:0] {
      WSE_LF_AND,
      WSE_LF_OR,
      WSE_LF_XOR,
      WSE_LF_RSV
   } wse_lfunc_t;
   // One 32-bit state instruction
   typedef struct packed {
      logic decide;
      logic reexec;
      logic inc_addr;
      logic next_fifo;
      logic irq;
      logic drive_data;
      logic sample_data;
      logic [5:0] ctl_level;
      logic [5:0] ctl_oe;
      wse_lfunc_t lfunc;
      logic [2:0] term_a;
      logic [2:0] term_b;
      logic [4:0] spare;
   } wse_instr_t;
   typedef struct packed {
      logic [7:0] count;
      logic [2:0] br1;
      logic [2:0] br0;
   } wse_branch_t;
   typedef enum logic {
      WSE_ST_IDLE,
      WSE_ST_RUN
   } wse_state_t;
endpackage

// file: testbench/wse_periph_model.sv
// Purpose: Peripheral on the far side of the engine
// Assumes: Wait line 0 high means peripheral ready
// Notes: Read data changes every cycle
`timescale 1ns/1ps
module wse_periph_model (
   input wire logic clk_i,
   input wire logic stall_i,
   input wire logic [5:0] ctl_i,
   output logic [5:0] wait_o,
   output logic flag_o,
   output logic [15:0] data_o
);
   // -------------------------
   // Ready, flag and read data
   // -------------------------
   assign wait_o = {5'h00, !stall_i};
   assign flag_o = ctl_i[0];
   initial data_o = 16'h0001;
   always @(posedge clk_i) data_o <= {data_o[14:0], data_o[15]} ^ 16'h8000;
endmodule

// file: testbench/wse_chk_assertions.sv
// Purpose: Bus and idle checks on wse_engine ports
// Assumes: Idle registers written only while idle
// Notes: Idle checks wait for settled config
`timescale 1ns/1ps
`include "wse_cfg.svh"
module wse_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [15:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic fifo_data_bus_oe_o,
   input wire logic [5:0] control_strobe_out_o,
   input wire logic [5:0] control_strobe_out_oe_o,
   input wire logic completion_irq_o
);
   // ----------------------
   // Shadow of idle config
   // ----------------------
   logic [7:0] lvl;
   logic [7:0] cfg;
   logic drv;
   logic busy;
   logic [2:0] known;
   logic [2:0] settle;
   wire logic wr = cyc_i && stb_i && !ack_o && we_i && sel_i[0];
   wire logic idle_ok = known == 3'h7 && !busy && settle == 3'h7;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         known <= 3'h0;
      end else if (wr && adr_i == `WSE_OFF_IDLE_CTL) begin
         lvl <= dat_i[7:0];
         known[0] <= 1'b1;
      end else if (wr && adr_i == `WSE_OFF_CTL_CFG) begin
         cfg <= dat_i[7:0];
         known[1] <= 1'b1;
      end else if (wr && adr_i == `WSE_OFF_IDLE_CS) begin
         drv <= dat_i[0];
         known[2] <= 1'b1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || completion_irq_o) busy <= 1'b0;
      else if (wr && adr_i == `WSE_OFF_TRIG) busy <= 1'b1;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || wr || busy) settle <= 3'h0;
      else if (settle != 3'h7) settle <= settle + 3'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_read(logic [15:0] a);
      s_take ##0 (!we_i && adr_i == a);
   endsequence
   a_ack_timing: assert property (s_take |=> ack_o ##1 !ack_o) else $error("ack timing");
   a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("ack without request");
   a_done_read: assert property (idle_ok ##0 s_read(`WSE_OFF_IDLE_CS) |=> dat_o[7])
      else $error("done bit low in idle");
   a_irq_pulse: assert property (completion_irq_o |=> !completion_irq_o)
      else $error("completion not a pulse");
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && !completion_irq_o)
      else $error("outputs active after reset");
   a_ctl_levels: assert property (idle_ok && !cfg[7] |-> control_strobe_out_o == lvl[5:0]
      && control_strobe_out_oe_o == ~(lvl[5:0] & cfg[5:0])) else $error("idle controls");
   a_ctl_tristate: assert property (idle_ok && cfg[7] |-> control_strobe_out_o[3:0] == lvl[3:0]
      && control_strobe_out_oe_o == {2'h0, lvl[7:4]}) else $error("idle tristate controls");
   a_bus_float: assert property (idle_ok && !drv |-> !fifo_data_bus_oe_o) else $error("bus driven");
endmodule
bind wse_engine wse_chk chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
   .ack_o, .fifo_data_bus_oe_o, .control_strobe_out_o, .control_strobe_out_oe_o, .completion_irq_o);

// file: testbench/tb_top.sv
// Purpose: Self-checking bench for wse_engine
// Assumes: Descriptor n serves transfer type n
// Notes: State counts come from instruction byte 3; drive_data makes them at least 4
`timescale 1ns/1ps
`include "wse_cfg.svh"
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [15:0] adr_i = 16'h0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [15:0] wr_data_i = 16'hA5C3;
   logic [31:0] dat_o;
   logic ack_o, fifo_flag_i, bus_oe, adv, ev, done_irq, rd_valid;
   logic [5:0] wait_in_i, ctl, ctl_oe;
   logic [15:0] bus_o, bus_in, per_data, rd_data;
   logic [8:0] addr_o;
   int mismatches = 0;
   int n_tests = 0;
   int ev_cnt = 0;
   int adv_cnt = 0;
   int rv_cnt = 0;
   assign bus_in = bus_oe ? bus_o : per_data;
   wse_engine dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .wait_in_i, .fifo_flag_i, .fifo_data_bus_i(bus_in), .wr_data_i, .fifo_data_bus_o(bus_o),
      .fifo_data_bus_oe_o(bus_oe), .control_strobe_out_o(ctl), .control_strobe_out_oe_o(ctl_oe),
      .engine_address_out_o(addr_o), .fifo_advance_o(adv), .waveform_event_irq_o(ev),
      .completion_irq_o(done_irq), .rd_data_o(rd_data), .rd_valid_o(rd_valid));
   wse_periph_model per_u (.clk_i, .stall_i(1'b1), .ctl_i(ctl), .wait_o(wait_in_i), .flag_o(fifo_flag_i),
      .data_o(per_data));
   always #20 clk_i = ~clk_i;
   always @(posedge clk_i) if (ev === 1'b1) ev_cnt++;
   always @(posedge clk_i) if (adv === 1'b1) adv_cnt++;
   always @(posedge clk_i) if (rd_valid === 1'b1) rv_cnt++;
   // ----------------
   // Shared tasks
   // ----------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 20) chk(32'h0, 32'h1, "no ack");
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hF, q);
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, 4'hF, q);
   endtask
   function automatic logic [31:0] ins(input logic dec, input logic irq);
      wse_pkg::wse_instr_t i;
      i = '0;
      i.decide = dec;
      i.irq = irq;
      i.drive_data = 1'b1;
      i.ctl_level = 6'h15;
      i.ctl_oe = 6'h3F;
      return i;
   endfunction
   task automatic idle_case(input logic [7:0] cf, input logic [7:0] lv, input logic [11:0] m,
      input logic [11:0] e);
      wr(`WSE_OFF_CTL_CFG, {24'h0, cf});
      wr(`WSE_OFF_IDLE_CTL, {24'h0, lv});
      repeat (2) @(posedge clk_i);
      chk({20'h0, {ctl_oe, ctl} & m}, {20'h0, e}, "idle controls");
   endtask
   // ----------------
   // Scenarios
   // ----------------
   task automatic t_regs();
      logic [31:0] q;
      rd(`WSE_OFF_IDLE_CS, q);
      chk(q[7], 1'b1, "done after reset");
      rd(`WSE_OFF_WF_SEL, q);
      chk(q[7:0], `WSE_WF_SEL_RST, "select reset");
      rd(16'h0040, q);
      chk(q, 32'h0, "unmapped");
      wr(`WSE_OFF_IF_CFG, 32'h0);
      wr(`WSE_MEM_BASE, 32'h1234_5678);
      rd(`WSE_MEM_BASE, q);
      chk(q, 32'h0, "memory gated");
      wr(`WSE_OFF_IF_CFG, {30'h0, `WSE_IF_ENGINE});
      wr(`WSE_MEM_LAST - 16'h3, 32'hA1B2_C3D4);
      bus(1'b1, `WSE_MEM_LAST - 16'h3, 32'h0000_5A00, 4'h2, q);
      rd(`WSE_MEM_LAST - 16'h3, q);
      chk(q, 32'hA1B2_5AD4, "byte rewrite");
   endtask
   task automatic t_wave();
      logic [31:0] q;
      int n;
      wr(`WSE_OFF_IDLE_CS, 32'h0);
      chk(bus_oe, 1'b0, "idle bus float");
      idle_case(8'h00, 8'h2D, 12'hFFF, 12'hFED);
      idle_case(8'h0F, 8'h2D, 12'hFFF, 12'hCAD);
      idle_case(8'h80, 8'hA6, 12'hFCF, 12'h286);
      wr(`WSE_OFF_IDLE_CS, 32'h1);
      // State 3 increments address, advances pointer and samples data
      for (int s = 0; s < 7; s++) wr(`WSE_MEM_BASE + 16'(4 * s), ins(1'b0, s == 2) | (s == 3 ? 32'h3200_0000 : 32'h0));
      ev_cnt = 0;
      adv_cnt = 0;
      rv_cnt = 0;
      wr(`WSE_OFF_TRIG, 32'h0);
      n = 0;
      while (done_irq !== 1'b1 && n < 4000) begin
         @(posedge clk_i);
         n++;
      end
      chk(n >= 6 && n < 4000, 1'b1, "wave length");
      chk(ev_cnt, 1, "event count");
      chk(adv_cnt, 1, "fifo advance count");
      chk({23'h0, addr_o}, 32'h1, "address increment");
      chk(rv_cnt > 0, 1'b1, "data sampled");
      rd(`WSE_OFF_TRIG, q);
      chk(q[7], 1'b1, "done after wave");
      chk({bus_oe, bus_o}, {1'b1, wr_data_i}, "idle drive");
   endtask
   task automatic t_abort();
      logic [31:0] q;
      int n;
      wr(`WSE_MEM_BASE + 16'h20, ins(1'b1, 1'b0));
      wr(`WSE_OFF_TRIG, 32'h1);
      rd(`WSE_OFF_IDLE_CS, q);
      chk(q[7], 1'b0, "busy done bit");
      chk({ctl_oe, ctl}, 12'hFD5, "state controls");
      wr(`WSE_OFF_ABORT, 32'h0);
      n = 0;
      do begin
         rd(`WSE_OFF_IDLE_CS, q);
         n++;
      end while (q[7] !== 1'b1 && n < 10);
      chk(q[7], 1'b1, "abort ends wave");
   endtask
   task automatic tally_and_finish();
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #(40 * 12000);
      mismatches++;
      tally_and_finish();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_wave();
      t_abort();
      tally_and_finish();
   end
endmodule
